// ==== rbs_pkg.sv ====
package rbs_pkg;

  // reset vector in internal rom
  localparam logic [23:0] RBS_RESET_VECTOR     = 24'hFF_FF00;
  // pll settings for 375x of the 32.768 kHz clock
  localparam logic [9:0]  RBS_PLL_MULT_375     = 10'h2ED;
  localparam logic [1:0]  RBS_PLL_SEC_375      = 2'h0;
  localparam logic [1:0]  RBS_PLL_ODIV_375     = 2'h0;
  // pll multiplier fields for about 36 mhz (3x and 1125x)
  localparam logic [9:0]  RBS_PLL_MULT_3X      = 10'h002;
  localparam logic [9:0]  RBS_PLL_MULT_1125X   = 10'h464;
  // parallel port mode values tried during the serial probe
  localparam logic [2:0]  RBS_PPMODE_FIRST     = 3'h5;
  localparam logic [2:0]  RBS_PPMODE_SECOND    = 3'h6;
  // i2c target address and bus rates
  localparam logic [6:0]  RBS_I2C_TARGET       = 7'h50;
  localparam int          RBS_SPI_RATE_KHZ     = 500;
  localparam int          RBS_I2C_RATE_KHZ     = 400;
  // expected 2-byte signature, value arbitrary
  localparam logic [15:0] RBS_SIGNATURE        = 16'hA53C;
  // first and last asynchronous chip-select space probed
  localparam logic [1:0]  RBS_CS_FIRST         = 2'h0;
  localparam logic [1:0]  RBS_CS_LAST          = 2'h3;
  // rtc register window
  localparam logic [15:0] RBS_RTC_BASE         = 16'h1900;
  localparam logic [15:0] RBS_RTC_LAST         = 16'h197F;
  // settling delay
  localparam int          RBS_CLK_KHZ          = 10_000;
  localparam int          RBS_SETTLE_MS        = 200;
  localparam int          RBS_SETTLE_CYC       = RBS_SETTLE_MS * RBS_CLK_KHZ;
  // peripheral clock enables, one bit each
  localparam int          RBS_NPERIPH          = 5;
  localparam int          RBS_PER_EMIF         = 0;
  localparam int          RBS_PER_SPI          = 1;
  localparam int          RBS_PER_I2C          = 2;
  localparam int          RBS_PER_MMC          = 3;
  localparam int          RBS_PER_USB          = 4;

  typedef enum logic [2:0] {
    RBS_SRC_NOR   = 3'h0,
    RBS_SRC_NAND  = 3'h1,
    RBS_SRC_SPI16 = 3'h2,
    RBS_SRC_SPI24 = 3'h3,
    RBS_SRC_I2C   = 3'h4,
    RBS_SRC_MMC   = 3'h5,
    RBS_SRC_USB   = 3'h6
  } rbs_src_e;

  // one probe request to the memory access engine
  typedef struct packed {
    rbs_src_e    src;
    logic [1:0]  cs;
    logic [2:0]  ppmode;
    logic [6:0]  i2c_addr;
  } rbs_probe_s;

  // pll setting driven to the clock generator
  typedef struct packed {
    logic       bypass;
    logic       power_up;
    logic [9:0] mult;
    logic [1:0] sec;
    logic [1:0] odiv;
    logic       div8;
  } rbs_pll_s;

endpackage

// ==== rbs_sig_check.sv ====
`timescale 1ns/1ps
`default_nettype none
module rbs_sig_check
  import rbs_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        valid_i,
  input  wire logic [15:0] data_i,
  output logic             done_o,
  output logic             match_o
);
  logic done_reg;
  logic match_reg;

  // bus-idle patterns never equal the constant, so they fail naturally
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      done_reg  <= 1'b0;
      match_reg <= 1'b0;
    end else begin
      done_reg  <= valid_i;
      if (valid_i) begin
        match_reg <= (data_i == RBS_SIGNATURE);
      end
    end
  end

  assign done_o  = done_reg;
  assign match_o = match_reg;
endmodule
`default_nettype wire

// ==== rbs_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module rbs_sequencer
  import rbs_pkg::*;
#(
  parameter int SETTLE_CYC = RBS_SETTLE_CYC
) (
  input  wire logic                    clock_i,
  input  wire logic                    reset_i,
  input  wire logic                    clock_source_select_i,
  input  wire logic                    rtc_osc_enabled_i,
  input  wire logic [15:0]             rtc_access_addr_i,
  output logic                         rtc_access_allow_o,
  output logic [23:0]                  fetch_addr_o,
  output logic                         rom_map_select_o,
  output logic                         clock_output_slow_slew_o,
  output logic                         clock_output_enable_o,
  output logic                         bandgap_trim_o,
  output logic                         idle_all_o,
  output logic                         cpu_domain_idle_o,
  output rbs_pll_s                     pll_o,
  output logic [RBS_NPERIPH-1:0]       periph_clk_en_o,
  output logic                         probe_req_o,
  output rbs_probe_s                   probe_o,
  output logic                         probe_wide_o,
  input  wire logic                    probe_done_i,
  input  wire logic [15:0]             probe_data_i,
  input  wire logic                    regcfg_present_i,
  output logic                         regcfg_start_o,
  input  wire logic                    regcfg_done_i,
  output logic                         copy_start_o,
  input  wire logic                    copy_done_i,
  output logic                         timer_running_o,
  output logic                         jump_o,
  output rbs_src_e                     boot_src_o
);

  typedef enum logic [3:0] {
    RBS_ST_VECTOR  = 4'h0,
    RBS_ST_IDLE    = 4'h1,
    RBS_ST_PLL     = 4'h2,
    RBS_ST_TRIM    = 4'h3,
    RBS_ST_PROBE   = 4'h4,
    RBS_ST_WAIT    = 4'h5,
    RBS_ST_NEXT    = 4'h6,
    RBS_ST_USBPLL  = 4'h7,
    RBS_ST_REGCFG  = 4'h8,
    RBS_ST_COPY    = 4'h9,
    RBS_ST_SETTLE  = 4'hA,
    RBS_ST_JUMP    = 4'hB
  } rbs_state_e;

  rbs_state_e        state_reg;
  rbs_src_e          src_reg;
  logic [1:0]        cs_reg;
  logic [2:0]        ppmode_reg;
  logic              wait_chk_reg;
  logic              timer_en_reg;
  logic [31:0]       timer_reg;
  logic              timer_done;
  logic              chk_done;
  logic              chk_match;
  logic              last_try;
  rbs_pll_s          pll_reg;
  logic              slew_reg;
  logic              clock_output_pin_reg;
  logic              trim_reg;
  logic              idle_reg;
  logic [RBS_NPERIPH-1:0] pclk_reg;

  rbs_sig_check rbs_sig_check_i (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .valid_i (probe_done_i && state_reg == RBS_ST_WAIT),
    .data_i  (probe_data_i),
    .done_o  (chk_done),
    .match_o (chk_match)
  );

  // last attempt of a source: last cs, or second port mode for spi
  always_comb begin
    last_try = 1'b1;
    if (src_reg == RBS_SRC_NOR || src_reg == RBS_SRC_NAND) begin
      last_try = (cs_reg == RBS_CS_LAST);
    end else if (src_reg == RBS_SRC_SPI16 || src_reg == RBS_SRC_SPI24) begin
      last_try = (ppmode_reg == RBS_PPMODE_SECOND);
    end
  end

  assign timer_done = (timer_reg >= SETTLE_CYC);

  // main sequence
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state_reg    <= RBS_ST_VECTOR;
      src_reg      <= RBS_SRC_NOR;
      cs_reg       <= RBS_CS_FIRST;
      ppmode_reg   <= RBS_PPMODE_FIRST;
      wait_chk_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        RBS_ST_VECTOR: state_reg <= RBS_ST_IDLE;
        RBS_ST_IDLE:   state_reg <= RBS_ST_PLL;
        RBS_ST_PLL:    state_reg <= RBS_ST_TRIM;
        RBS_ST_TRIM:   state_reg <= RBS_ST_PROBE;
        RBS_ST_PROBE: begin
          state_reg    <= RBS_ST_WAIT;
          wait_chk_reg <= 1'b0;
        end
        RBS_ST_WAIT: begin
          if (probe_done_i) begin
            wait_chk_reg <= 1'b1;
          end
          if (chk_done && wait_chk_reg) begin
            if (chk_match && src_reg != RBS_SRC_USB) begin
              state_reg <= RBS_ST_REGCFG;
            end else if (chk_match) begin
              state_reg <= RBS_ST_REGCFG;
            end else begin
              state_reg <= RBS_ST_NEXT;
            end
          end
        end
        RBS_ST_NEXT: begin
          state_reg <= RBS_ST_PROBE;
          if (src_reg == RBS_SRC_USB) begin
            src_reg <= RBS_SRC_USB;
          end else if (!last_try) begin
            if (src_reg == RBS_SRC_NOR || src_reg == RBS_SRC_NAND) begin
              cs_reg <= cs_reg + 2'h1;
            end else begin
              ppmode_reg <= RBS_PPMODE_SECOND;
            end
          end else begin
            cs_reg     <= RBS_CS_FIRST;
            ppmode_reg <= RBS_PPMODE_FIRST;
            unique case (src_reg)
              RBS_SRC_NOR:   src_reg <= RBS_SRC_NAND;
              RBS_SRC_NAND:  src_reg <= RBS_SRC_SPI16;
              RBS_SRC_SPI16: src_reg <= RBS_SRC_SPI24;
              RBS_SRC_SPI24: src_reg <= RBS_SRC_I2C;
              RBS_SRC_I2C:   src_reg <= RBS_SRC_MMC;
              default: begin
                src_reg   <= RBS_SRC_USB;
                state_reg <= RBS_ST_USBPLL;
              end
            endcase
          end
        end
        RBS_ST_USBPLL: state_reg <= RBS_ST_PROBE;
        RBS_ST_REGCFG: begin
          if (!regcfg_present_i || regcfg_done_i) begin
            state_reg <= RBS_ST_COPY;
          end
        end
        RBS_ST_COPY: begin
          if (copy_done_i) begin
            state_reg <= RBS_ST_SETTLE;
          end
        end
        RBS_ST_SETTLE: begin
          if (timer_done) begin
            state_reg <= RBS_ST_JUMP;
          end
        end
        RBS_ST_JUMP: state_reg <= RBS_ST_JUMP;
        default: state_reg <= RBS_ST_VECTOR;
      endcase
    end
  end

  // settling timer, started when copying finishes; the image is trusted
  // not to touch it, since nothing here can guard against that
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      timer_en_reg <= 1'b0;
      timer_reg    <= 32'h0000_0000;
    end else begin
      if (state_reg == RBS_ST_COPY && copy_done_i) begin
        timer_en_reg <= 1'b1;
      end
      if (timer_en_reg && !timer_done) begin
        timer_reg <= timer_reg + 32'h0000_0001;
      end
    end
  end

  // clock generator and pad setup
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pll_reg    <= '{bypass: 1'b1, power_up: 1'b0, mult: 10'h000,
                      sec: 2'h0, odiv: 2'h0, div8: 1'b0};
      slew_reg   <= 1'b0;
      clock_output_pin_reg <= 1'b1;
      trim_reg   <= 1'b0;
      idle_reg   <= 1'b0;
    end else begin
      if (state_reg == RBS_ST_IDLE) begin
        slew_reg <= 1'b1;
        idle_reg <= 1'b1;
      end
      if (state_reg == RBS_ST_PLL && !clock_source_select_i) begin
        pll_reg <= '{bypass: 1'b0, power_up: 1'b1, mult: RBS_PLL_MULT_375,
                     sec: RBS_PLL_SEC_375, odiv: RBS_PLL_ODIV_375,
                     div8: 1'b1};
      end
      if (state_reg == RBS_ST_PLL && clock_source_select_i) begin
        pll_reg.bypass <= 1'b1;
      end
      if (state_reg == RBS_ST_TRIM) begin
        trim_reg   <= 1'b1;
        clock_output_pin_reg <= 1'b0;
      end
      if (state_reg == RBS_ST_USBPLL) begin
        pll_reg <= '{bypass: 1'b0, power_up: 1'b1,
                     mult: clock_source_select_i ? RBS_PLL_MULT_3X
                                                 : RBS_PLL_MULT_1125X,
                     sec: 2'h0, odiv: 2'h0, div8: 1'b0};
      end
    end
  end

  // peripheral clock: only the one being probed runs
  generate
    for (genvar p = 0; p < RBS_NPERIPH; p++) begin : g_pclk
      logic hit;
      always_comb begin
        hit = 1'b0;
        unique case (src_reg)
          RBS_SRC_NOR, RBS_SRC_NAND:   hit = (p == RBS_PER_EMIF);
          RBS_SRC_SPI16, RBS_SRC_SPI24: hit = (p == RBS_PER_SPI);
          RBS_SRC_I2C:                 hit = (p == RBS_PER_I2C);
          RBS_SRC_MMC:                 hit = (p == RBS_PER_MMC);
          default:                     hit = (p == RBS_PER_USB);
        endcase
      end
      always_ff @(posedge clock_i) begin
        if (reset_i) begin
          pclk_reg[p] <= 1'b0;
        end else begin
          pclk_reg[p] <= hit && state_reg inside {RBS_ST_PROBE, RBS_ST_WAIT,
                         RBS_ST_REGCFG, RBS_ST_COPY};
        end
      end
    end
  endgenerate

  assign periph_clk_en_o          = pclk_reg;
  assign pll_o                    = pll_reg;
  assign fetch_addr_o             = RBS_RESET_VECTOR;
  assign rom_map_select_o         = 1'b0;
  assign clock_output_slow_slew_o = slew_reg;
  assign clock_output_enable_o    = clock_output_pin_reg;
  assign bandgap_trim_o           = trim_reg;
  assign idle_all_o               = idle_reg || state_reg == RBS_ST_JUMP;
  assign cpu_domain_idle_o        = 1'b0;
  assign probe_req_o              = (state_reg == RBS_ST_PROBE);
  assign probe_o                  = '{src: src_reg, cs: cs_reg,
                                      ppmode: ppmode_reg,
                                      i2c_addr: RBS_I2C_TARGET};
  // nor uses 16-bit data, nand 8-bit
  assign probe_wide_o             = (src_reg == RBS_SRC_NOR);
  assign regcfg_start_o           = (state_reg == RBS_ST_REGCFG) &&
                                    regcfg_present_i;
  assign copy_start_o             = (state_reg == RBS_ST_COPY);
  assign timer_running_o          = timer_en_reg;
  assign jump_o                   = (state_reg == RBS_ST_JUMP);
  assign boot_src_o               = src_reg;
  // rtc registers unreachable while its oscillator is off
  assign rtc_access_allow_o = rtc_osc_enabled_i ||
    !(rtc_access_addr_i >= RBS_RTC_BASE &&
      rtc_access_addr_i <= RBS_RTC_LAST);

endmodule
`default_nettype wire

// ==== rbs_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module rbs_checker
  import rbs_pkg::*;
#(
  parameter int SETTLE_CYC = RBS_SETTLE_CYC
) (
  input wire logic                   clock_i,
  input wire logic                   reset_i,
  input wire logic                   clock_source_select_i,
  input wire logic                   clock_output_slow_slew_o,
  input wire logic                   clock_output_enable_o,
  input wire logic                   bandgap_trim_o,
  input wire logic                   idle_all_o,
  input wire rbs_pll_s               pll_o,
  input wire logic [RBS_NPERIPH-1:0] periph_clk_en_o,
  input wire logic                   probe_req_o,
  input wire rbs_probe_s             probe_o,
  input wire logic                   timer_running_o,
  input wire logic                   jump_o
);
  // saturates so a long settle never wraps
  int unsigned settle_reg;
  always_ff @(posedge clock_i) begin
    if (reset_i || !timer_running_o) settle_reg <= 0;
    else if (settle_reg < SETTLE_CYC) settle_reg <= settle_reg + 1;
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  pll_375_a: assert property (
    probe_req_o && probe_o.src == RBS_SRC_NOR && !clock_source_select_i
    |-> pll_o == {2'b01, RBS_PLL_MULT_375, RBS_PLL_SEC_375,
                  RBS_PLL_ODIV_375, 1'b1})
    else $error("pll not at 375x setting");
  pll_bypass_a: assert property (
    probe_req_o && probe_o.src != RBS_SRC_USB && clock_source_select_i
    |-> pll_o.bypass) else $error("pll not bypassed");
  usb_pll_a: assert property (
    probe_req_o && probe_o.src == RBS_SRC_USB |-> pll_o.mult ==
    (clock_source_select_i ? RBS_PLL_MULT_3X : RBS_PLL_MULT_1125X))
    else $error("pll wrong for usb");
  trim_order_a: assert property (
    probe_req_o |-> clock_output_slow_slew_o && bandgap_trim_o &&
    !clock_output_enable_o && idle_all_o) else $error("setup not done");
  emif_clock_a: assert property (
    probe_req_o && probe_o.src inside {RBS_SRC_NOR, RBS_SRC_NAND}
    |=> periph_clk_en_o == (RBS_NPERIPH'(1) << RBS_PER_EMIF))
    else $error("memory port clock wrong");
  one_clock_a: assert property (
    $onehot0(periph_clk_en_o)) else $error("two clocks on");
  settle_wait_a: assert property (
    $rose(jump_o) |-> settle_reg >= SETTLE_CYC)
    else $error("jump before settle");
  handoff_a: assert property (
    jump_o |-> periph_clk_en_o == '0 && idle_all_o)
    else $error("handoff state wrong");
endmodule
bind rbs_sequencer rbs_checker #(.SETTLE_CYC(SETTLE_CYC)) rbs_checker_i (
  .clock_i(clock_i), .reset_i(reset_i),
  .clock_source_select_i(clock_source_select_i),
  .clock_output_slow_slew_o(clock_output_slow_slew_o),
  .clock_output_enable_o(clock_output_enable_o),
  .bandgap_trim_o(bandgap_trim_o), .idle_all_o(idle_all_o),
  .pll_o(pll_o), .periph_clk_en_o(periph_clk_en_o),
  .probe_req_o(probe_req_o), .probe_o(probe_o),
  .timer_running_o(timer_running_o), .jump_o(jump_o));
`default_nettype wire

// ==== rbs_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module rbs_mem_model
  import rbs_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic       probe_req_i,
  input  wire rbs_probe_s probe_i,
  input  wire rbs_src_e   win_src_i,
  input  wire logic [1:0] win_cs_i,
  input  wire logic       usb_ok_i,
  input  wire logic [3:0] lat_i,
  input  wire logic       regcfg_start_i,
  input  wire logic       copy_start_i,
  output logic            probe_done_o,
  output logic [15:0]     probe_data_o,
  output logic            regcfg_done_o,
  output logic            copy_done_o
);
  logic [3:0] wait_reg;
  logic       busy_reg;
  logic [3:0] rc_reg;
  logic [3:0] cp_reg;
  logic       hit;
  assign hit = probe_i.src == win_src_i &&
               (probe_i.src > RBS_SRC_NAND || probe_i.cs == win_cs_i) &&
               (probe_i.src != RBS_SRC_USB || usb_ok_i);
  // released data toggles so a late sample never sees a stale word
  always_ff @(posedge clock_i) begin
    probe_done_o <= 1'b0;
    wait_reg <= wait_reg - 4'h1;
    probe_data_o <= ~probe_data_o;
    if (reset_i) begin
      busy_reg <= 1'b0;
    end else if (probe_req_i) begin
      busy_reg <= 1'b1;
      wait_reg <= lat_i;
    end else if (busy_reg && wait_reg == 4'h0) begin
      busy_reg <= 1'b0;
      probe_done_o <= 1'b1;
      probe_data_o <= hit ? RBS_SIGNATURE : 16'hFFFF;
    end
  end
  // config writes touch neither clocks nor the timer
  always_ff @(posedge clock_i) begin
    rc_reg <= (reset_i || !regcfg_start_i) ? 4'h0 : rc_reg + 4'(rc_reg != 4'hF);
    cp_reg <= (reset_i || !copy_start_i) ? 4'h0 : cp_reg + 4'(cp_reg != 4'hF);
  end
  assign regcfg_done_o = regcfg_start_i && rc_reg == lat_i;
  assign copy_done_o = copy_start_i && cp_reg == lat_i;
endmodule
`default_nettype wire

// ==== reset_boot_sequencer_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module reset_boot_sequencer_test
  import rbs_pkg::*;
;
  localparam int SETTLE_SIM = 50;
  logic        clock_i;
  logic        reset_i;
  logic        wide;
  logic        cpu_idle;
  logic [2:0]  ppm;
  logic        sel;
  logic        osc;
  logic [15:0] addr;
  logic        allow;
  logic [23:0] fetch;
  logic        rom_sel;
  logic        req;
  rbs_probe_s  probe;
  logic        done;
  logic [15:0] data;
  logic        present;
  logic        rc_go;
  logic        rc_done;
  logic        cp_go;
  logic        cp_done;
  logic        timer;
  logic        jump;
  logic [4:0]  clk_en;
  rbs_pll_s    pll;
  rbs_src_e    src;
  rbs_src_e    win;
  logic [1:0]  win_cs;
  logic        usb_ok;
  logic [3:0]  lat;
  logic        rc_seen;
  int          idx;
  int          mismatches;
  int          num_checks;
  rbs_sequencer #(.SETTLE_CYC(SETTLE_SIM)) rbs_sequencer_i (
    .clock_i(clock_i), .reset_i(reset_i), .clock_source_select_i(sel),
    .rtc_osc_enabled_i(osc), .rtc_access_addr_i(addr),
    .rtc_access_allow_o(allow), .fetch_addr_o(fetch),
    .rom_map_select_o(rom_sel), .clock_output_slow_slew_o(),
    .clock_output_enable_o(), .bandgap_trim_o(), .idle_all_o(),
    .cpu_domain_idle_o(cpu_idle), .pll_o(pll), .periph_clk_en_o(clk_en),
    .probe_req_o(req), .probe_o(probe), .probe_wide_o(wide),
    .probe_done_i(done), .probe_data_i(data),
    .regcfg_present_i(present), .regcfg_start_o(rc_go),
    .regcfg_done_i(rc_done), .copy_start_o(cp_go),
    .copy_done_i(cp_done), .timer_running_o(timer), .jump_o(jump),
    .boot_src_o(src));
  rbs_mem_model rbs_mem_model_i (
    .clock_i(clock_i), .reset_i(reset_i), .probe_req_i(req),
    .probe_i(probe), .win_src_i(win), .win_cs_i(win_cs),
    .usb_ok_i(usb_ok), .lat_i(lat), .regcfg_start_i(rc_go),
    .copy_start_i(cp_go), .probe_done_o(done), .probe_data_o(data),
    .regcfg_done_o(rc_done), .copy_done_o(cp_done));
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function automatic rbs_src_e exp_src(input int i);
    if (i < 4) return RBS_SRC_NOR;
    if (i < 8) return RBS_SRC_NAND;
    if (i < 10) return RBS_SRC_SPI16;
    if (i < 12) return RBS_SRC_SPI24;
    if (i == 12) return RBS_SRC_I2C;
    if (i == 13) return RBS_SRC_MMC;
    return RBS_SRC_USB;
  endfunction
  always @(posedge clock_i) begin
    if (req === 1'b1 && !reset_i) begin
      chk(probe.src, exp_src(idx));
      if (idx < 8) chk(probe.cs, idx % 4);
      if (idx < 8) chk(wide, idx < 4);
      if (idx inside {[8:11]}) begin
        ppm = idx[0] ? RBS_PPMODE_SECOND : RBS_PPMODE_FIRST;
        chk(probe.ppmode, ppm);
      end
      if (idx == 12) chk(probe.i2c_addr, RBS_I2C_TARGET);
      idx++;
    end
    if (rc_go === 1'b1) rc_seen = 1'b1;
  end
  task automatic boot(input logic s, input rbs_src_e w, input logic [1:0] c,
                      input logic p, input int n);
    int k;
    int t;
    t = 0;
    sel = s;
    win = w;
    win_cs = c;
    present = p;
    usb_ok = 1'b0;
    lat = 4'(n % 6);
    reset_i = 1'b1;
    repeat (5) @(negedge clock_i);
    chk(clk_en, 5'h00);
    chk({rom_sel, fetch}, {1'b0, RBS_RESET_VECTOR});
    idx = 0;
    rc_seen = 1'b0;
    reset_i = 1'b0;
    for (k = 0; k < 3000 && jump !== 1'b1; k++) begin
      @(negedge clock_i);
      // usb answers only once its oscillator is enabled and settled
      usb_ok = idx > 16;
      if (timer === 1'b1 && jump !== 1'b1) t++;
    end
    // a hang counts once; the run still ends in the closing report
    if (jump !== 1'b1) mismatches++;
    chk(idx, n);
    chk(src, w);
    chk(rc_seen, p);
    chk(t >= SETTLE_SIM, 1'b1);
    chk(clk_en, 5'h00);
    chk(cpu_idle, 1'b0);
  endtask
  task automatic t_nor();
    boot(1'b0, RBS_SRC_NOR, 2'h3, 1'b1, 4);
    chk(pll.mult, RBS_PLL_MULT_375);
    $display("nor test done");
  endtask
  task automatic t_nand();
    boot(1'b1, RBS_SRC_NAND, 2'h0, 1'b0, 5);
    chk(pll.bypass, 1'b1);
    $display("nand test done");
  endtask
  task automatic t_spi();
    boot(1'b1, RBS_SRC_SPI16, 2'h0, 1'b0, 9);
    boot(1'b0, RBS_SRC_SPI24, 2'h0, 1'b1, 11);
    $display("spi retry test done");
  endtask
  task automatic t_i2c();
    boot(1'b1, RBS_SRC_I2C, 2'h0, 1'b0, 13);
    boot(1'b0, RBS_SRC_MMC, 2'h0, 1'b1, 14);
    $display("i2c test done");
  endtask
  // usb answers only after two refused rounds
  task automatic t_usb();
    boot(1'b1, RBS_SRC_USB, 2'h0, 1'b0, 17);
    chk(pll.mult, RBS_PLL_MULT_3X);
    boot(1'b0, RBS_SRC_USB, 2'h0, 1'b1, 17);
    chk(pll.mult, RBS_PLL_MULT_1125X);
    $display("usb loop test done");
  endtask
  task automatic t_rtc();
    logic [15:0] a [4] = '{16'h18FF, 16'h1900, 16'h197F, 16'h1980};
    for (int o = 0; o < 2; o++) begin
      for (int k = 0; k < 4; k++) begin
        @(negedge clock_i);
        osc = o[0];
        addr = a[k];
        #1 chk(allow, o == 1 || k == 0 || k == 3);
      end
    end
    $display("rtc window test done");
  endtask
  initial begin
    mismatches = 0;
    num_checks = 0;
    reset_i = 1'b1;
    osc = 1'b1;
    addr = 16'h0000;
    idx = 0;
    t_nor();
    t_nand();
    t_spi();
    t_i2c();
    t_usb();
    t_rtc();
    close_out();
  end
endmodule
`default_nettype wire
